// [logic/paging_ctrl_pkg.sv]
// Constants, field positions and packet layout of the control-packet block.
// Assumes a 20 MHz system clock and 32-bit packets, identifier in byte 3.
//
// Notes on behaviour
// - Run bit set decodes; clear enters low power.
// - Run toggles within 2 ms may cancel.
// - All-frame mode when counters nonzero or forced.
// - All-frame mode decodes and flags every frame end.
// - Temporary address assignment increments its counter.
// - Message vectors increment the all-frame counter.
// - Counters saturate between 0 and 127.
// - Counters clear on reset and run off.
// - Identifier 3 carries decrement and force bits.
// - Decrement request lowers all-frame counter by one.
// - Each set bit lowers its counter; zero disables.
// - Identifier 4 holds sixteen operator address enables.
// - Operator enables never change frame selection.
// - Identifier 5 holds the roaming control fields.
// - Ignore-resync reports resync instead of going asynchronous.
// - Network check reports bit and abandons bad frames.
// - Abandon keeps sync, or ends asynchronous search.
// - Manual collapse uses 7 and reports received collapse.
// - Assigned frames repeat by collapse; forced do not.
package paging_ctrl_pkg;

    // ****************************************************************
    // Packet layout
    // ****************************************************************
    typedef struct packed {
        logic [7:0] id;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } packet_type;

    localparam logic [7:0] ID_CONTROL = 8'h02;
    localparam logic [7:0] ID_ALL_FRAME = 8'h03;
    localparam logic [7:0] ID_OPERATOR = 8'h04;
    localparam logic [7:0] ID_ROAMING = 8'h05;
    localparam int RUN_BIT = 0;
    localparam int DAF_BIT = 7;
    localparam int FAF_BIT = 6;
    localparam int IRS_BIT = 7;
    localparam int NBC_BIT = 6;
    localparam int MCM_BIT = 5;
    localparam int MFC_LSB = 4;
    localparam int MCO_LSB = 0;
    localparam int PACKET_BITS = 32;
    localparam int TEMP_ADDRS = 16;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
    localparam logic [2:0] MANUAL_COLLAPSE = 3'h7;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [6:0] OFS_PACKET = 7'h00;
    localparam logic [6:0] OFS_STATUS = 7'h04;
    localparam logic [6:0] OFS_SETTINGS = 7'h08;
    localparam logic [6:0] OFS_COUNT_BASE = 7'h40;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int RUN_GUARD_MS = 2;
    localparam int RUN_GUARD_CYCLES = RUN_GUARD_MS * (CLK_HZ / 1000);

endpackage

// [logic/paging_ctrl.sv]
// Control-packet interpreter of the paging decoder: run bit, all-frame
// counters, operator address enables and roaming controls.
// Assumes packets on a three-wire serial link from the host and the same
// packets, plus status, over an Avalon-MM slave; decoder events arrive as
// pulses from logic on clk_in.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module paging_ctrl
    import paging_ctrl_pkg::*;
#(
    parameter int RUN_GUARD = RUN_GUARD_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Serial packet link from the host.
    input wire logic link_clk_in,
    input wire logic link_data_in,
    input wire logic link_sel_n_in,
    // Avalon-MM register slave.
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Decoder events.
    input wire logic temp_assign_in,
    input wire logic [3:0] temp_index_in,
    input wire logic msg_vector_in,
    input wire logic frame_end_in,
    input wire logic [6:0] frame_num_in,
    input wire logic [127:0] assigned_frame_bits_in,
    input wire logic resync_detect_in,
    input wire logic fiw_valid_in,
    input wire logic fiw_uncorrectable_in,
    input wire logic fiw_network_bit_in,
    input wire logic synchronous_in,
    input wire logic collapse_valid_in,
    input wire logic [2:0] collapse_in,
    // Decoder controls.
    output logic run_out,
    output logic low_power_out,
    output logic all_frame_mode_out,
    output logic eof_status_out,
    output logic frame_decode_out,
    output logic [15:0] temp_enables_out,
    output logic [15:0] operator_address_enables_out,
    output logic go_async_out,
    output logic abandon_frame_out,
    output logic end_aword_search_out,
    output logic [1:0] missed_frame_control_out,
    output logic [1:0] max_carry_on_out
);

    // ****************************************************************
    // Serial link receiver
    // ****************************************************************
    logic [2:0] sync1_q, sync2_q;
    logic link_clk_old_q;
    logic [5:0] bit_cnt_q;
    logic [31:0] shift_q;
    logic ser_pend_q;
    packet_type ser_pkt_q;
    logic link_rise;

    // Two flops per pin before anything looks at the link.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // Idle pin levels: deselected, data high, clock parked low.
            sync1_q <= 3'h6;
            sync2_q <= 3'h6;
            link_clk_old_q <= 1'b0;
        end else begin
            sync1_q <= {link_sel_n_in, link_data_in, link_clk_in};
            sync2_q <= sync1_q;
            link_clk_old_q <= sync2_q[0];
        end
    end

    assign link_rise = sync2_q[0] & ~link_clk_old_q;

    // whole packet first
    // Bits arrive most significant first; deselect discards a partial word.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bit_cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
        end else if (sync2_q[2]) begin
            bit_cnt_q <= 6'h00;
        end else if (link_rise) begin
            shift_q <= {shift_q[30:0], sync2_q[1]};
            bit_cnt_q <= (bit_cnt_q == 6'(PACKET_BITS - 1)) ? 6'h00
                : bit_cnt_q + 6'h01;
        end
    end

    logic bus_pkt;
    logic pkt_valid;
    packet_type pkt;

    // A finished serial packet waits while a bus write is being applied.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ser_pend_q <= 1'b0;
            ser_pkt_q <= '0;
        end else if (link_rise && !sync2_q[2] &&
                     bit_cnt_q == 6'(PACKET_BITS - 1)) begin
            ser_pend_q <= 1'b1;
            ser_pkt_q <= {shift_q[30:0], sync2_q[1]};
        end else if (!bus_pkt) begin
            ser_pend_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    logic ack_q;
    logic [31:0] rdata_q;
    logic accept;
    logic status_rd;
    logic [31:0] status_word;
    logic [31:0] settings_word;
    logic [CNT_W-1:0] ta_cnt_q [TEMP_ADDRS];
    logic [CNT_W-1:0] af_cnt_q;

    // One wait cycle on every access; the answer stands in the second.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign accept = (avs_read | avs_write) & ack_q;
    assign bus_pkt = accept & avs_write & (avs_address == OFS_PACKET)
        & (avs_byteenable == 4'hf);
    assign status_rd = accept & avs_read & (avs_address == OFS_STATUS);
    assign avs_readdata = rdata_q;
    assign pkt_valid = bus_pkt | ser_pend_q;
    assign pkt = bus_pkt ? packet_type'(avs_writedata) : ser_pkt_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
            if (avs_read && !ack_q) begin
                if (avs_address == OFS_STATUS) begin
                    rdata_q <= status_word;
                end else if (avs_address == OFS_SETTINGS) begin
                    rdata_q <= settings_word;
                end else if (avs_address == OFS_COUNT_BASE - 7'h04) begin
                    rdata_q <= {25'h0, af_cnt_q};
                end else if (avs_address >= OFS_COUNT_BASE) begin
                    rdata_q <= {25'h0, ta_cnt_q[avs_address[5:2]]};
                end else begin
                    rdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // ****************************************************************
    // Run bit with its double-change guard
    // ****************************************************************
    logic run_q, run_req_q;
    logic [$clog2(RUN_GUARD+1)-1:0] guard_q;
    logic ctl_pkt;

    assign ctl_pkt = pkt_valid && pkt.id == ID_CONTROL;

    // double change guard
    // A change waits out the guard; a toggle back inside it cancels both,
    // so a fast off-on pulse leaves the decoder in its original state.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            run_q <= 1'b0;
            run_req_q <= 1'b0;
            guard_q <= '0;
        end else if (ctl_pkt && pkt.b0[RUN_BIT] != run_req_q) begin
            run_req_q <= pkt.b0[RUN_BIT];
            guard_q <= (pkt.b0[RUN_BIT] == run_q) ? '0
                : ($bits(guard_q))'(RUN_GUARD);
        end else if (guard_q == ($bits(guard_q))'(1)) begin
            guard_q <= '0;
            run_q <= run_req_q;
        end else if (guard_q != '0) begin
            guard_q <= guard_q - ($bits(guard_q))'(1);
        end
    end

    assign run_out = run_q;
    assign low_power_out = ~run_q;

    // ****************************************************************
    // Packet fields: forced frames, operator enables, roaming
    // ****************************************************************
    logic [7:0] forced_frame_bits_q;
    logic force_every_frame_q;
    logic [15:0] oae_q;
    logic ignore_resync_q, network_check_q, manual_collapse_q;
    logic [1:0] mfc_q, mco_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            forced_frame_bits_q <= 8'h00;
            force_every_frame_q <= 1'b0;
            oae_q <= 16'h0000;
            {ignore_resync_q, network_check_q, manual_collapse_q} <= 3'h0;
            mfc_q <= 2'h0;
            mco_q <= 2'h0;
        end else if (pkt_valid) begin
            if (pkt.id == ID_CONTROL) begin
                forced_frame_bits_q <= pkt.b2;
            end else if (pkt.id == ID_ALL_FRAME) begin
                force_every_frame_q <= pkt.b2[FAF_BIT];
            end else if (pkt.id == ID_OPERATOR) begin
                oae_q <= {pkt.b1, pkt.b0};
            end else if (pkt.id == ID_ROAMING) begin
                ignore_resync_q <= pkt.b2[IRS_BIT];
                network_check_q <= pkt.b2[NBC_BIT];
                manual_collapse_q <= pkt.b2[MCM_BIT];
                mfc_q <= pkt.b0[MFC_LSB +: 2];
                mco_q <= pkt.b0[MCO_LSB +: 2];
            end
        end
    end

    assign operator_address_enables_out = oae_q;
    assign missed_frame_control_out = mfc_q;
    assign max_carry_on_out = mco_q;

    // ****************************************************************
    // Saturating all-frame and temporary-address counters
    // ****************************************************************
    logic af_pkt;
    logic [15:0] ta_dec;

    assign af_pkt = pkt_valid && pkt.id == ID_ALL_FRAME;
    assign ta_dec = af_pkt ? {pkt.b1, pkt.b0} : 16'h0000;

    // saturating step
    // Increment and decrement in one cycle cancel; ends never wrap.
    function automatic logic [CNT_W-1:0] sat_step(
        input logic [CNT_W-1:0] cnt, input logic inc, input logic dec);
        logic [CNT_W-1:0] nxt;
        nxt = cnt;
        if (inc && !dec && cnt != CNT_MAX) begin
            nxt = cnt + 7'h01;
        end else if (dec && !inc && cnt != '0) begin
            nxt = cnt - 7'h01;
        end
        return nxt;
    endfunction

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            af_cnt_q <= '0;
        end else if (!run_q) begin
            af_cnt_q <= '0;
        end else begin
            af_cnt_q <= sat_step(af_cnt_q, msg_vector_in,
                af_pkt & pkt.b2[DAF_BIT]);
        end
    end

    for (genvar i = 0; i < TEMP_ADDRS; i++) begin : g_temp
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                ta_cnt_q[i] <= '0;
            end else if (!run_q) begin
                ta_cnt_q[i] <= '0;
            end else begin
                ta_cnt_q[i] <= sat_step(ta_cnt_q[i],
                    temp_assign_in && temp_index_in == 4'(i), ta_dec[i]);
            end
        end
        assign temp_enables_out[i] = ta_cnt_q[i] != '0;
    end

    assign all_frame_mode_out = (|temp_enables_out) | (af_cnt_q != '0)
        | force_every_frame_q;

    // ****************************************************************
    // Frame selection
    // ****************************************************************
    logic [2:0] eff_collapse;
    logic [6:0] frame_mask;
    logic eof_q, decode_q;

    assign eff_collapse = manual_collapse_q ? MANUAL_COLLAPSE : collapse_in;
    assign frame_mask = 7'((8'h01 << eff_collapse) - 8'h01);

    // frame choice
    // Operator enables stay out of this term on purpose.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            decode_q <= 1'b0;
            eof_q <= 1'b0;
        end else begin
            decode_q <= run_q & (all_frame_mode_out
                | assigned_frame_bits_in[frame_num_in & frame_mask]
                | (frame_num_in < 7'h08
                   & forced_frame_bits_q[frame_num_in[2:0]]));
            eof_q <= run_q & all_frame_mode_out & frame_end_in;
        end
    end

    assign frame_decode_out = decode_q;
    assign eof_status_out = eof_q;

    // ****************************************************************
    // Roaming events and status flags
    // ****************************************************************
    logic rsr_q, nbu_q, nbit_q, scu_q;
    logic [2:0] rsc_q;
    logic async_q, abandon_q, end_search_q;
    logic bad_frame;

    assign bad_frame = fiw_valid_in & network_check_q
        & (fiw_uncorrectable_in | ~fiw_network_bit_in);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            async_q <= 1'b0;
            abandon_q <= 1'b0;
            end_search_q <= 1'b0;
        end else begin
            async_q <= resync_detect_in & ~ignore_resync_q;
            abandon_q <= bad_frame;
            end_search_q <= bad_frame & ~synchronous_in;
        end
    end

    // sticky flags
    // Reading status clears the three flags, but an event in that cycle wins; nbit_q and rsc_q hold.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {rsr_q, nbu_q, nbit_q, scu_q} <= 4'h0;
            rsc_q <= 3'h0;
        end else begin
            rsr_q <= (resync_detect_in & ignore_resync_q)
                | (rsr_q & ~status_rd);
            nbu_q <= (fiw_valid_in & network_check_q) | (nbu_q & ~status_rd);
            scu_q <= (collapse_valid_in & manual_collapse_q)
                | (scu_q & ~status_rd);
            if (fiw_valid_in && network_check_q) begin
                nbit_q <= fiw_network_bit_in;
            end
            if (collapse_valid_in && manual_collapse_q) begin
                rsc_q <= collapse_in;
            end
        end
    end

    assign go_async_out = async_q;
    assign abandon_frame_out = abandon_q;
    assign end_aword_search_out = end_search_q;
    assign status_word = {22'h0, rsc_q, scu_q, nbit_q, nbu_q, rsr_q,
        all_frame_mode_out, run_req_q, run_q};
    assign settings_word = {oae_q, forced_frame_bits_q, mfc_q, mco_q,
        ignore_resync_q, network_check_q, manual_collapse_q,
        force_every_frame_q};

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_run_off_clears;
        @(posedge clk_in) disable iff (sys_rst_in)
        !run_q |=> af_cnt_q == '0 && !temp_enables_out[0];
    endproperty
    a_run_off_clears: assert property (p_run_off_clears)
        else $error("Counters not cleared while decoder is off.");

    property p_mode;
        @(posedge clk_in) disable iff (sys_rst_in)
        (af_cnt_q != '0 || force_every_frame_q) |-> all_frame_mode_out;
    endproperty
    a_mode: assert property (p_mode)
        else $error("All-frame mode missing with a cause present.");

    property p_saturate;
        @(posedge clk_in) disable iff (sys_rst_in)
        run_q && af_cnt_q == CNT_MAX && !(af_pkt && pkt.b2[DAF_BIT])
        |=> af_cnt_q == CNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("All-frame counter wrapped past its top.");

    property p_decrement;
        @(posedge clk_in) disable iff (sys_rst_in)
        run_q && af_pkt && pkt.b2[DAF_BIT] && !msg_vector_in
        && af_cnt_q != '0 |=> af_cnt_q == $past(af_cnt_q) - 7'h01;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("Decrement request did not lower the counter.");

    property p_operator;
        @(posedge clk_in) disable iff (sys_rst_in)
        pkt_valid && pkt.id == ID_OPERATOR
        |=> operator_address_enables_out == $past({pkt.b1, pkt.b0});
    endproperty
    a_operator: assert property (p_operator)
        else $error("Operator enables not loaded from packet.");

    property p_guard;
        @(posedge clk_in) disable iff (sys_rst_in)
        run_q != $past(run_q) |-> $past(guard_q) == 1;
    endproperty
    a_guard: assert property (p_guard)
        else $error("Run bit changed before the guard ran out.");

    property p_ignore_resync;
        @(posedge clk_in) disable iff (sys_rst_in)
        resync_detect_in && ignore_resync_q |=> rsr_q && !go_async_out;
    endproperty
    a_ignore_resync: assert property (p_ignore_resync)
        else $error("Ignored resync still went asynchronous.");

    property p_abandon;
        @(posedge clk_in) disable iff (sys_rst_in)
        fiw_valid_in && network_check_q
        && (fiw_uncorrectable_in || !fiw_network_bit_in)
        |=> abandon_frame_out
        && end_aword_search_out != $past(synchronous_in);
    endproperty
    a_abandon: assert property (p_abandon)
        else $error("Bad frame info word not abandoned.");

endmodule

// [test/host_link.sv]
// Host model: sends 32-bit packets, MSB first, on the serial link.
// Assumes the block samples the link with its own faster clock.
`timescale 1ns/1ps
module host_link (
    // Serial link towards the block.
    output logic link_clk_out,
    output logic link_data_out,
    output logic link_sel_n_out
);
    // ****************************************************************
    // Packet sender
    // ****************************************************************
    // The link idles deselected with its clock parked low.
    initial begin
        link_clk_out = 1'b0;
        link_data_out = 1'b1;
        link_sel_n_out = 1'b1;
    end
    // whole packet framing
    // The clock stands still between frames, and the data line turns over
    // on release so that a stale bit is never mistaken for a held one.
    task automatic send(input logic [31:0] pkt);
        #37 link_sel_n_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            link_data_out = pkt[i];
            #100 link_clk_out = 1'b1;
            #200 link_clk_out = 1'b0;
            #100;
        end
        link_data_out = ~pkt[0];
        link_sel_n_out = 1'b1;
    endtask
endmodule

// [test/paging_ctrl_test.sv]
// Bench of the control-packet block: bus and serial packets, events.
// Assumes the host model in host_link and a 20 MHz system clock.
`timescale 1ns/1ps
module paging_ctrl_test;
    import paging_ctrl_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int G = 20;
    logic clk_in, sys_rst_in, lclk, ldat, lsel_n;
    logic [6:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic ta, mv, fe, rs, fv, fu, fn, sy, cv;
    logic [3:0] ti;
    logic [6:0] fnum;
    logic [127:0] afb;
    logic [2:0] col;
    logic run, lp, afm, eof, ga, ab, ea, fd;
    logic [15:0] ten, operator_address_enables;
    logic [1:0] missed_frame_control, max_carry_on;
    logic [31:0] exp_q[$];
    logic [31:0] v;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    paging_ctrl #(.RUN_GUARD(G)) DUT (
        .clk_in, .sys_rst_in, .link_clk_in(lclk), .link_data_in(ldat),
        .link_sel_n_in(lsel_n), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .temp_assign_in(ta), .temp_index_in(ti), .msg_vector_in(mv),
        .frame_end_in(fe), .frame_num_in(fnum),
        .assigned_frame_bits_in(afb), .resync_detect_in(rs),
        .fiw_valid_in(fv), .fiw_uncorrectable_in(fu),
        .fiw_network_bit_in(fn), .synchronous_in(sy),
        .collapse_valid_in(cv), .collapse_in(col), .run_out(run),
        .low_power_out(lp), .all_frame_mode_out(afm),
        .eof_status_out(eof), .frame_decode_out(fd),
        .temp_enables_out(ten), .operator_address_enables_out(operator_address_enables),
        .go_async_out(ga), .abandon_frame_out(ab),
        .end_aword_search_out(ea), .missed_frame_control_out(missed_frame_control),
        .max_carry_on_out(max_carry_on));
    host_link host (.link_clk_out(lclk), .link_data_out(ldat),
        .link_sel_n_out(lsel_n));
    // The system clock runs free at 20 MHz.
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // A hung handshake is cut short here and counted as a mismatch.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    // Read data are taken at the edge where waitrequest is seen low.
    always @(posedge clk_in) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk(avs_readdata, exp_q.pop_front());
    end
    // The request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [6:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pkt(input packet_type p);
        bus(1'b1, OFS_PACKET, p);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    // One-cycle event pulses; the check point is the following low phase.
    task automatic fire(input logic [5:0] m);
        @(posedge clk_in);
        {ta, mv, fe, rs, fv, cv} <= m;
        @(posedge clk_in);
        {ta, mv, fe, rs, fv, cv} <= 6'h0;
        @(negedge clk_in);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {avs_read, avs_write, ta, mv, fe, rs, fv, fu, fn, sy, cv} = '0;
        avs_address = 7'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        ti = 4'h0;
        fnum = 7'h0;
        col = 3'h0;
        void'($urandom(32'h6afd76a4));
        afb = {4{$urandom()}};
        sys_rst_in = 1'b1;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        wt(2);
        chk(run, 0);
        chk(lp, 1);
        rd(OFS_STATUS, 0);
        rd(OFS_SETTINGS, 0);
        rd(7'h20, 0);
        $display("Test reset finished");
        host.send({ID_CONTROL, 24'h000001});
        wt(G + 12);
        chk(run, 1);
        chk(lp, 0);
        // Toggle back inside the guard, breaking the spacing on purpose.
        pkt({ID_CONTROL, 24'h0});
        pkt({ID_CONTROL, 24'h1});
        wt(G + 5);
        chk(run, 1);
        $display("Test run finished");
        repeat (130) fire(6'h10);
        rd(7'h3c, 127);
        chk(afm, 1);
        pkt({ID_ALL_FRAME, 24'h800000});
        rd(7'h3c, 126);
        pkt({ID_ALL_FRAME, 24'h00ffff});
        rd(7'h3c, 126);
        rd(7'h40, 0);
        v = $urandom();
        ti <= v[3:0];
        fire(6'h20);
        rd(7'h40 + {v[3:0], 2'b00}, 1);
        chk(ten, 32'h1 << v[3:0]);
        pkt({ID_ALL_FRAME, 8'h0, 16'h1 << v[3:0]});
        wt(1);
        chk(ten, 0);
        $display("Test counters finished");
        pkt({ID_CONTROL, 24'h0});
        wt(G + 5);
        rd(7'h3c, 0);
        chk(afm, 0);
        pkt({ID_CONTROL, 24'h1});
        wt(G + 5);
        pkt({ID_CONTROL, 24'h0});
        wt(G + 5);
        chk(lp, 1);
        pkt({ID_CONTROL, 24'h1});
        wt(G + 5);
        pkt({ID_ALL_FRAME, 24'h400000});
        wt(1);
        chk(afm, 1);
        fire(6'h08);
        chk(eof, 1);
        pkt({ID_ALL_FRAME, 24'h0});
        wt(1);
        chk(afm, 0);
        // Collapse 0: assigned bit 0 alone picks every frame.
        chk(fd, afb[0]);
        pkt({ID_CONTROL, 8'h01, 16'h0001});
        afb[0] <= 1'b0;
        wt(2);
        chk(fd, 1);
        $display("Test all frame finished");
        v = $urandom();
        host.send({ID_OPERATOR, 8'h0, v[15:0]});
        wt(10);
        chk(operator_address_enables, v[15:0]);
        for (int k = 0; k < 4; k++) begin
            pkt({ID_ROAMING, 16'he000, 2'b0, 2'(k), 2'b0, ~2'(k)});
            col <= 3'h5;
            wt(1);
            chk(missed_frame_control, k);
            chk(max_carry_on, 3 - k);
        end
        fire(6'h07);
        chk(ga, 0);
        chk(ab, 1);
        chk(ea, 1);
        rd(OFS_STATUS, 32'h2db);
        rd(OFS_STATUS, 32'h283);
        // Network check stays on: a synchronous decoder keeps its channel.
        pkt({ID_ROAMING, 24'h400000});
        sy <= 1'b1;
        fire(6'h06);
        chk(ga, 1);
        chk(ab, 1);
        chk(ea, 0);
        $display("Test roaming finished");
        stop_test();
    end
endmodule
